// *** design/aabs_pkg.sv ***
// Constants and types shared by the accumulator ALU, skip and bit-operation block.
// Assumes one core clock and a plain register port with reads answered one cycle later.
package aabs_pkg;

  localparam int DATA_W = 8;
  localparam int REG_ADDR_W = 7;
  localparam int BIT_IDX_W = 3;
  localparam int BUS_ADDR_W = 4;

  // Register port map
  localparam logic [BUS_ADDR_W-1:0] ADDR_ACC = 4'h0;
  localparam logic [BUS_ADDR_W-1:0] ADDR_STATUS = 4'h1;
  localparam logic [BUS_ADDR_W-1:0] ADDR_PINS = 4'h2;

  // Status register fields
  localparam int STAT_CARRY = 0;
  localparam int STAT_HALF = 1;
  localparam int STAT_ZERO = 2;
  localparam int STAT_SKIP = 3;

  // Register-file address that maps onto the I/O port
  localparam logic [REG_ADDR_W-1:0] PORT_REG_ADDR = 7'h05;

  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;
  localparam int NIBBLE_MSB = 3;

  typedef enum logic [3:0] {
    no_op,
    add_literal_op,
    add_register_op,
    and_literal_op,
    and_register_op,
    bit_clear_op,
    bit_set_op,
    skip_if_bit_zero_op,
    skip_if_bit_one_op
  } aabs_op_t;

  // One-hot mask for a bit index
  function automatic logic [DATA_W-1:0] aabs_bit_mask(input logic [BIT_IDX_W-1:0] idx);
    aabs_bit_mask = BYTE_ONE << idx;
  endfunction

  // True when the operation takes its operand from the register file
  function automatic logic aabs_reads_reg(input aabs_op_t op);
    aabs_reads_reg = (op != no_op) && (op != add_literal_op) && (op != and_literal_op);
  endfunction

endpackage

// *** design/aabs_alu_if.sv ***
// Carrier between the execution top and its arithmetic unit.
// Assumes both ends sit on the same clock; all signals are combinational.
`timescale 1ns/1ps
interface aabs_alu_if;
  import aabs_pkg::*;
  aabs_op_t op;
  logic dest_reg;
  logic [DATA_W-1:0] acc;
  logic [DATA_W-1:0] opnd;
  logic [BIT_IDX_W-1:0] bit_idx;
  logic [DATA_W-1:0] result;
  logic carry;
  logic half;
  logic zero;
  logic wr_acc;
  logic wr_reg;
  logic upd_carry;
  logic upd_zero;
  logic skip;

  modport main (output op, dest_reg, acc, opnd, bit_idx,
                input result, carry, half, zero, wr_acc, wr_reg, upd_carry, upd_zero, skip);
  modport alu (input op, dest_reg, acc, opnd, bit_idx,
               output result, carry, half, zero, wr_acc, wr_reg, upd_carry, upd_zero, skip);
endinterface

// *** design/aabs_alu.sv ***
// Combinational arithmetic, logic, bit-modify and bit-test unit.
// Assumes the operand already carries pin levels or forwarded data where needed.
`timescale 1ns/1ps
module aabs_alu (
  aabs_alu_if.alu alu_if
);
  import aabs_pkg::*;

  wire [DATA_W:0] sum_full = {1'b0, alu_if.acc} + {1'b0, alu_if.opnd};
  wire [NIBBLE_MSB+1:0] sum_low = {1'b0, alu_if.acc[NIBBLE_MSB:0]} +
                                  {1'b0, alu_if.opnd[NIBBLE_MSB:0]};
  wire [DATA_W-1:0] and_val = alu_if.acc & alu_if.opnd;
  wire [DATA_W-1:0] mask = aabs_bit_mask(alu_if.bit_idx);
  wire tested_bit = |(alu_if.opnd & mask);

  wire is_add = (alu_if.op == add_literal_op) || (alu_if.op == add_register_op);
  wire is_and = (alu_if.op == and_literal_op) || (alu_if.op == and_register_op);
  wire is_lit = (alu_if.op == add_literal_op) || (alu_if.op == and_literal_op);
  wire is_byte_reg = (alu_if.op == add_register_op) || (alu_if.op == and_register_op);
  wire is_bit_mod = (alu_if.op == bit_clear_op) || (alu_if.op == bit_set_op);

  assign alu_if.result = is_add ? sum_full[DATA_W-1:0] :
                         is_and ? and_val :
                         (alu_if.op == bit_clear_op) ? (alu_if.opnd & ~mask) :
                         (alu_if.op == bit_set_op) ? (alu_if.opnd | mask) :
                         BYTE_ZERO;
  assign alu_if.carry = sum_full[DATA_W];
  assign alu_if.half = sum_low[NIBBLE_MSB+1];
  assign alu_if.zero = (alu_if.result == BYTE_ZERO);
  // Literal forms always land in the accumulator; byte forms follow the destination bit
  assign alu_if.wr_acc = is_lit || (is_byte_reg && !alu_if.dest_reg);
  assign alu_if.wr_reg = is_bit_mod || (is_byte_reg && alu_if.dest_reg);
  assign alu_if.upd_carry = is_add;
  assign alu_if.upd_zero = is_add || is_and;
  assign alu_if.skip = ((alu_if.op == skip_if_bit_zero_op) && !tested_bit) ||
                       ((alu_if.op == skip_if_bit_one_op) && tested_bit);

endmodule

// *** design/aabs_exec.sv ***
// Execution stage for add, AND, bit set/clear and bit-test-skip instructions.
// Assumes the decoder presents one instruction per valid cycle and the register
// file answers a read combinationally and takes a write at the clock edge.
//
// What this block does
// - Add literal: accumulator plus literal into the accumulator, C, half-carry and Z updated.
// - Add register: accumulator plus register byte to accumulator (dest 0) or register (dest 1).
// - AND literal: accumulator AND literal into the accumulator, only Z updated.
// - AND register: accumulator AND register byte to accumulator or register, only Z updated.
// - Bit clear: force the indexed bit of the register byte to zero, flags untouched.
// - Bit set: force the indexed bit of the register byte to one, flags untouched.
// - Skip if zero: a clear tested bit discards the next instruction as a no-op, two cycles.
// - Skip if one: a set tested bit discards the next instruction as a no-op, two cycles.
// - Read-modify-write of the I/O port register reads the pin levels, not the latch.
`timescale 1ns/1ps
module aabs_exec (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  // Instruction from the decoder
  input wire logic instr_valid_in,
  input wire aabs_pkg::aabs_op_t instr_op_in,
  input wire logic [aabs_pkg::DATA_W-1:0] instr_literal_in,
  input wire logic [aabs_pkg::REG_ADDR_W-1:0] instr_reg_addr_in,
  input wire logic instr_dest_in,
  input wire logic [aabs_pkg::BIT_IDX_W-1:0] instr_bit_in,
  output logic instr_discard_out,
  output logic skip_pending_out,
  // Register file
  output logic [aabs_pkg::REG_ADDR_W-1:0] rf_raddr_out,
  input wire logic [aabs_pkg::DATA_W-1:0] rf_rdata_in,
  output logic rf_wr_out,
  output logic [aabs_pkg::REG_ADDR_W-1:0] rf_waddr_out,
  output logic [aabs_pkg::DATA_W-1:0] rf_wdata_out,
  // I/O port pins, asynchronous to the core
  input wire logic [aabs_pkg::DATA_W-1:0] port_pins_in,
  // Register port
  input wire logic [aabs_pkg::BUS_ADDR_W-1:0] bus_addr_in,
  input wire logic [aabs_pkg::DATA_W-1:0] bus_wdata_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_in,
  output logic [aabs_pkg::DATA_W-1:0] bus_rdata_out,
  // Architectural state
  output logic [aabs_pkg::DATA_W-1:0] acc_out,
  output logic carry_out,
  output logic nibble_half_flag_out,
  output logic zero_out
);
  import aabs_pkg::*;

  aabs_alu_if alu_if ();

  aabs_alu aabs_alu_i (
    .alu_if(alu_if)
  );

  // Architectural state
  logic [DATA_W-1:0] acc_ff;
  logic [DATA_W-1:0] nxt_acc;
  logic carry_ff;
  logic nxt_carry;
  logic half_ff;
  logic nxt_half;
  logic zero_ff;
  logic nxt_zero;

  // Skip tracking
  logic skip_pending_ff;
  logic nxt_skip_pending;
  logic discard_ff;

  // Register write in flight, also the forwarding source
  logic rf_wr_ff;
  logic [REG_ADDR_W-1:0] rf_waddr_ff;
  logic [DATA_W-1:0] rf_wdata_ff;

  // Register port read data
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;

  // Pin synchroniser: stage1 feeds only stage2
  logic [DATA_W-1:0] pin_s1_ff;
  logic [DATA_W-1:0] pin_s2_ff;
  logic [DATA_W-1:0] pin_s3_ff;
  logic [DATA_W-1:0] pin_stable_ff;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_s1_ff <= BYTE_ZERO;
      pin_s2_ff <= BYTE_ZERO;
      pin_s3_ff <= BYTE_ZERO;
    end else begin
      pin_s1_ff <= port_pins_in;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  // Per-bit acceptance once two stages agree, filtering one-cycle glitches
  wire [DATA_W-1:0] nxt_pin_stable;
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_pin
      assign nxt_pin_stable[gi] = (pin_s2_ff[gi] == pin_s3_ff[gi]) ? pin_s3_ff[gi] :
                                  pin_stable_ff[gi];
    end
  endgenerate

  // One process owns the whole stable view, so every bit has a single driver
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_stable_ff <= BYTE_ZERO;
    end else begin
      pin_stable_ff <= nxt_pin_stable;
    end
  end

  // An instruction that follows a taken skip is dropped whole
  wire exec_en = instr_valid_in && !skip_pending_ff;
  wire drop_now = instr_valid_in && skip_pending_ff;
  wire uses_reg = aabs_reads_reg(instr_op_in);

  // Forward a write still in flight, since the file takes it only at the edge
  wire fwd_hit = rf_wr_ff && (rf_waddr_ff == instr_reg_addr_in);
  wire is_port = (instr_reg_addr_in == PORT_REG_ADDR);
  // Port reads use pin levels so input pins are not overwritten by a stale latch
  wire [DATA_W-1:0] reg_value = is_port ? pin_stable_ff :
                                fwd_hit ? rf_wdata_ff :
                                rf_rdata_in;

  assign rf_raddr_out = instr_reg_addr_in;
  assign alu_if.op = exec_en ? instr_op_in : no_op;
  assign alu_if.dest_reg = instr_dest_in;
  assign alu_if.acc = acc_ff;
  assign alu_if.opnd = uses_reg ? reg_value : instr_literal_in;
  assign alu_if.bit_idx = instr_bit_in;

  // Bus decode
  wire wr_acc_sel = bus_wr_in && (bus_addr_in == ADDR_ACC);
  wire wr_stat_sel = bus_wr_in && (bus_addr_in == ADDR_STATUS);
  wire [DATA_W-1:0] stat_carry_bit = DATA_W'(carry_ff) << STAT_CARRY;
  wire [DATA_W-1:0] stat_half_bit = DATA_W'(half_ff) << STAT_HALF;
  wire [DATA_W-1:0] stat_zero_bit = DATA_W'(zero_ff) << STAT_ZERO;
  wire [DATA_W-1:0] stat_skip_bit = DATA_W'(skip_pending_ff) << STAT_SKIP;
  wire [DATA_W-1:0] status_view = stat_carry_bit | stat_half_bit |
                                  stat_zero_bit | stat_skip_bit;

  // Instruction results take priority over a software write in the same cycle
  always_comb begin
    nxt_acc = acc_ff;
    if (alu_if.wr_acc) begin
      nxt_acc = alu_if.result;
    end else if (wr_acc_sel) begin
      nxt_acc = bus_wdata_in;
    end
  end

  // Each flag on its own: an instruction update beats a software write
  always_comb begin
    nxt_carry = carry_ff;
    if (alu_if.upd_carry) begin
      nxt_carry = alu_if.carry;
    end else if (wr_stat_sel) begin
      nxt_carry = bus_wdata_in[STAT_CARRY];
    end
  end

  always_comb begin
    nxt_half = half_ff;
    if (alu_if.upd_carry) begin
      nxt_half = alu_if.half;
    end else if (wr_stat_sel) begin
      nxt_half = bus_wdata_in[STAT_HALF];
    end
  end

  always_comb begin
    nxt_zero = zero_ff;
    if (alu_if.upd_zero) begin
      nxt_zero = alu_if.zero;
    end else if (wr_stat_sel) begin
      nxt_zero = bus_wdata_in[STAT_ZERO];
    end
  end

  // Idle cycles keep a pending skip; only the next valid instruction uses it up
  always_comb begin
    nxt_skip_pending = skip_pending_ff;
    if (drop_now) begin
      nxt_skip_pending = 1'b0;
    end else if (exec_en) begin
      nxt_skip_pending = alu_if.skip;
    end
  end

  // Unmapped addresses read as zero
  always_comb begin
    unique case (bus_addr_in)
      ADDR_ACC: nxt_rdata = acc_ff;
      ADDR_STATUS: nxt_rdata = status_view;
      ADDR_PINS: nxt_rdata = pin_stable_ff;
      default: nxt_rdata = BYTE_ZERO;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      acc_ff <= ACC_RESET;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  // Flags clear at reset; software may preset them through the status register
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      carry_ff <= 1'b0;
    end else begin
      carry_ff <= nxt_carry;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      half_ff <= 1'b0;
    end else begin
      half_ff <= nxt_half;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      zero_ff <= 1'b0;
    end else begin
      zero_ff <= nxt_zero;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      skip_pending_ff <= 1'b0;
    end else begin
      skip_pending_ff <= nxt_skip_pending;
    end
  end

  // Discard marks the cycle after a dropped instruction, for the fetch side
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      discard_ff <= 1'b0;
    end else begin
      discard_ff <= drop_now;
    end
  end

  // Register writes leave as a one-cycle registered strobe
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rf_wr_ff <= 1'b0;
    end else begin
      rf_wr_ff <= alu_if.wr_reg;
    end
  end

  // Address and data hold after the strobe, so forwarding compares stay cheap
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rf_waddr_ff <= {REG_ADDR_W{1'b0}};
      rf_wdata_ff <= BYTE_ZERO;
    end else if (alu_if.wr_reg) begin
      rf_waddr_ff <= instr_reg_addr_in;
      rf_wdata_ff <= alu_if.result;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_ff <= BYTE_ZERO;
    end else if (bus_rd_in) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= BYTE_ZERO;
    end
  end

  // Instruction side
  assign instr_discard_out = discard_ff;
  assign skip_pending_out = skip_pending_ff;

  // Register file side
  assign rf_wr_out = rf_wr_ff;
  assign rf_waddr_out = rf_waddr_ff;
  assign rf_wdata_out = rf_wdata_ff;

  // Software view
  assign bus_rdata_out = rdata_ff;
  assign acc_out = acc_ff;
  assign carry_out = carry_ff;
  assign nibble_half_flag_out = half_ff;
  assign zero_out = zero_ff;

endmodule

// *** bench/aabs_exec_sva.sv ***
// Concurrent checks on the execution block, watching its top ports only.
// Assumes one clock and that bus writes never coincide with checked instructions.
`timescale 1ns/1ps
module aabs_exec_sva (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic instr_valid_in,
  input wire aabs_pkg::aabs_op_t instr_op_in,
  input wire logic [aabs_pkg::DATA_W-1:0] instr_literal_in,
  input wire logic [aabs_pkg::REG_ADDR_W-1:0] instr_reg_addr_in,
  input wire logic instr_dest_in,
  input wire logic [aabs_pkg::BIT_IDX_W-1:0] instr_bit_in,
  input wire logic instr_discard_out,
  input wire logic skip_pending_out,
  input wire logic [aabs_pkg::DATA_W-1:0] rf_rdata_in,
  input wire logic rf_wr_out,
  input wire logic [aabs_pkg::REG_ADDR_W-1:0] rf_waddr_out,
  input wire logic [aabs_pkg::DATA_W-1:0] rf_wdata_out,
  input wire logic bus_wr_in,
  input wire logic [aabs_pkg::DATA_W-1:0] acc_out,
  input wire logic carry_out,
  input wire logic nibble_half_flag_out,
  input wire logic zero_out
);
  import aabs_pkg::*;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  wire go = instr_valid_in && !skip_pending_out && !bus_wr_in;
  // Forwarded and pin-backed operands are not visible on rf_rdata_in
  wire fresh = !(rf_wr_out && rf_waddr_out == instr_reg_addr_in) &&
    instr_reg_addr_in != PORT_REG_ADDR;
  wire [7:0] mask = 8'h01 << instr_bit_in;
  wire [2:0] flags = {carry_out, nibble_half_flag_out, zero_out};
  sequence s_dropped;
    instr_discard_out && !rf_wr_out && !skip_pending_out && $stable(acc_out) && $stable(flags);
  endsequence
  sequence s_settled;
    !instr_discard_out;
  endsequence
  chk_add_lit_sum: assert property (
    go && instr_op_in == add_literal_op |=> {carry_out, acc_out} ==
    $past({1'b0, acc_out} + {1'b0, instr_literal_in}) && zero_out == (acc_out == 8'h00))
    else $error("literal add result wrong");
  chk_half_carry: assert property (
    go && instr_op_in == add_literal_op |=> nibble_half_flag_out ==
    ($past({1'b0, acc_out[3:0]} + {1'b0, instr_literal_in[3:0]}) > 5'h0F))
    else $error("nibble carry wrong");
  chk_and_lit_flags: assert property (
    go && instr_op_in == and_literal_op |=> acc_out == $past(acc_out & instr_literal_in)
    && $stable({carry_out, nibble_half_flag_out})) else $error("literal and wrong");
  chk_add_reg_wb: assert property (
    go && fresh && instr_op_in == add_register_op && instr_dest_in |=> rf_wr_out &&
    rf_waddr_out == $past(instr_reg_addr_in) && $stable(acc_out) &&
    rf_wdata_out == $past(8'(acc_out + rf_rdata_in))) else $error("register add wrong");
  chk_and_reg_acc: assert property (
    go && fresh && instr_op_in == and_register_op && !instr_dest_in |=> !rf_wr_out &&
    acc_out == $past(acc_out & rf_rdata_in)) else $error("register and wrong");
  chk_bit_modify: assert property (
    go && fresh && instr_op_in inside {bit_clear_op, bit_set_op} |=> rf_wr_out &&
    $stable(flags) && rf_wdata_out == $past(instr_op_in == bit_set_op ?
    rf_rdata_in | mask : rf_rdata_in & ~mask)) else $error("bit modify wrong");
  chk_skip_test: assert property (
    go && fresh && instr_op_in inside {skip_if_bit_zero_op, skip_if_bit_one_op} |=>
    $stable(flags) && skip_pending_out ==
    $past(rf_rdata_in[instr_bit_in] == (instr_op_in == skip_if_bit_one_op)))
    else $error("skip decision wrong");
  chk_skip_drop: assert property (
    instr_valid_in && skip_pending_out && !bus_wr_in |=> s_dropped ##1 s_settled)
    else $error("skipped instruction not dropped");
  chk_skip_hold: assert property (
    skip_pending_out && !instr_valid_in |=> skip_pending_out)
    else $error("skip lost on idle cycle");
endmodule

// *** bench/aabs_rf_model.sv ***
// Register file model on the far side of the execution block.
// Assumes combinational read and a write taken at the clock edge.
`timescale 1ns/1ps
module aabs_rf_model (
  input wire logic clk_in,
  input wire logic [aabs_pkg::REG_ADDR_W-1:0] raddr_in,
  output logic [aabs_pkg::DATA_W-1:0] rdata_out,
  input wire logic wr_in,
  input wire logic [aabs_pkg::REG_ADDR_W-1:0] waddr_in,
  input wire logic [aabs_pkg::DATA_W-1:0] wdata_in
);
  import aabs_pkg::*;
  logic [7:0] mem [128];
  // No forwarding here: a write lands only after its edge
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37);
  assign rdata_out = mem[raddr_in];
  always @(posedge clk_in) if (wr_in) mem[waddr_in] <= wdata_in;
endmodule

// *** bench/aabs_exec_bench.sv ***
// Self-checking bench for the execution block and its register file model.
// Assumes results show one cycle after each taken instruction or bus read.
`timescale 1ns/1ps
`define CMP(got, exp) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end
module aabs_exec_bench;
  import aabs_pkg::*;
  logic clk = 0, rst_n = 0, vld = 0, dest = 0, bwr = 0, brd = 0, vq = 0, rq = 0;
  aabs_op_t op = no_op;
  logic [7:0] lit = '0, pins = 8'hA5, bwd = '0, a_m = '0, m_m [128];
  logic [6:0] fa = '0;
  logic [2:0] bi = '0;
  logic [3:0] ba = '0;
  logic c_m = 0, h_m = 0, z_m = 0, s_m = 0;
  logic [28:0] e, eq[$];
  logic [7:0] bq[$];
  logic [31:0] n;
  int seed = 32'h9C1C3559, error_cnt = 0, samples_checked = 0, cyc = 0;
  wire [6:0] ra, wa;
  wire [7:0] rd, wd, brdat, acc;
  wire wr, disc, skp, c, h, z;
  aabs_exec aabs_exec_i (.core_clk_in(clk), .reset_n_in(rst_n), .instr_valid_in(vld),
    .instr_op_in(op), .instr_literal_in(lit), .instr_reg_addr_in(fa), .instr_dest_in(dest),
    .instr_bit_in(bi), .instr_discard_out(disc), .skip_pending_out(skp), .rf_raddr_out(ra),
    .rf_rdata_in(rd), .rf_wr_out(wr), .rf_waddr_out(wa), .rf_wdata_out(wd),
    .port_pins_in(pins), .bus_addr_in(ba), .bus_wdata_in(bwd), .bus_wr_in(bwr),
    .bus_rd_in(brd), .bus_rdata_out(brdat), .acc_out(acc), .carry_out(c),
    .nibble_half_flag_out(h), .zero_out(z));
  aabs_rf_model aabs_rf_model_i (.clk_in(clk), .raddr_in(ra), .rdata_out(rd), .wr_in(wr),
    .waddr_in(wa), .wdata_in(wd));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic idle(int k);
    vld <= 0;
    bwr <= 0;
    brd <= 0;
    repeat (k) @(posedge clk);
  endtask
  task automatic bus(logic w, logic [3:0] ad, logic [7:0] dat);
    vld <= 0;
    bwr <= w;
    brd <= !w;
    ba <= ad;
    bwd <= dat;
    if (!w) bq.push_back(ad == ADDR_ACC ? a_m : ad == ADDR_STATUS ?
      {4'h0, s_m, z_m, h_m, c_m} : ad == ADDR_PINS ? pins : 8'h00);
    else if (ad == ADDR_ACC) a_m = dat;
    else if (ad == ADDR_STATUS) {z_m, h_m, c_m} = dat[2:0];
    @(posedge clk);
  endtask
  task automatic ex(aabs_op_t o, logic [7:0] k, logic [6:0] f, logic d, logic [2:0] b);
    logic [7:0] v, r;
    logic [8:0] s;
    logic w, dr;
    v = (f == PORT_REG_ADDR) ? pins : m_m[f];
    r = a_m;
    w = 0;
    dr = s_m;
    if (s_m) s_m = 0;
    else begin
      if (o inside {add_literal_op, and_literal_op}) v = k;
      case (o)
        add_literal_op, add_register_op: begin
          s = a_m + v;
          r = s[7:0];
          c_m = s[8];
          h_m = ({1'b0, a_m[3:0]} + {1'b0, v[3:0]}) > 5'h0F;
          z_m = r == 8'h00;
        end
        and_literal_op, and_register_op: begin
          r = a_m & v;
          z_m = r == 8'h00;
        end
        bit_clear_op: r = v & ~(8'h01 << b);
        bit_set_op: r = v | (8'h01 << b);
        skip_if_bit_zero_op: s_m = !v[b];
        skip_if_bit_one_op: s_m = v[b];
        default: ;
      endcase
      w = o inside {bit_clear_op, bit_set_op} || (d && o inside {add_register_op, and_register_op});
      if (w) m_m[f] = r;
      else a_m = r;
    end
    eq.push_back({a_m, c_m, h_m, z_m, s_m, w, w ? {f, r} : 15'h0, dr});
    vld <= 1;
    bwr <= 0;
    brd <= 0;
    op <= o;
    lit <= k;
    fa <= f;
    dest <= d;
    bi <= b;
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    vq <= vld;
    rq <= brd;
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end
  always @(negedge clk) begin
    if (vq) begin
      e = eq.pop_front();
      `CMP({acc, c, h, z, skp, wr, wr ? {wa, wd} : 15'h0, disc}, e)
    end
    if (rq) begin
      e[7:0] = bq.pop_front();
      `CMP(brdat, e[7:0])
    end
  end
  initial begin
    for (int i = 0; i < 128; i++) m_m[i] = 8'(i * 37);
    repeat (8) @(posedge clk);
    rst_n <= 1;
    idle(6);
    bus(1, ADDR_ACC, 8'h0F);
    ex(add_literal_op, 8'h01, 7'h00, 0, 3'h0);
    ex(add_literal_op, 8'hF0, 7'h00, 0, 3'h0);
    bus(0, ADDR_STATUS, 8'h00);
    bus(0, 4'hF, 8'h00);
    bus(1, ADDR_STATUS, 8'h00);
    // Register 0x10 holds 0x50: bit 0 clear, bit 4 set
    ex(skip_if_bit_zero_op, 8'h00, 7'h10, 0, 3'h0);
    idle(1);
    bus(0, ADDR_STATUS, 8'h00);
    ex(add_register_op, 8'h00, 7'h10, 1, 3'h0);
    ex(skip_if_bit_one_op, 8'h00, 7'h10, 0, 3'h4);
    ex(skip_if_bit_one_op, 8'h00, 7'h10, 0, 3'h4);
    ex(bit_clear_op, 8'h00, 7'h10, 0, 3'h4);
    ex(add_register_op, 8'h00, 7'h10, 1, 3'h0);
    ex(bit_set_op, 8'h00, PORT_REG_ADDR, 0, 3'h1);
    ex(and_register_op, 8'h00, PORT_REG_ADDR, 0, 3'h0);
    pins <= 8'($random(seed));
    idle(6);
    bus(0, ADDR_PINS, 8'h00);
    repeat (600) begin
      n = $random(seed);
      if (n[1:0] == 2'b00) idle(1);
      else if (n[4:2] == 3'b000) bus(n[25], n[29:26], n[13:6]);
      else ex(aabs_op_t'(n[31:28] % 4'h9), n[13:6], n[20:14], n[21], n[24:22]);
    end
    idle(3);
    summarize();
  end
endmodule
bind aabs_exec aabs_exec_sva aabs_exec_sva_i (.core_clk_in(core_clk_in),
  .reset_n_in(reset_n_in), .instr_valid_in(instr_valid_in), .instr_op_in(instr_op_in),
  .instr_literal_in(instr_literal_in), .instr_reg_addr_in(instr_reg_addr_in),
  .instr_dest_in(instr_dest_in), .instr_bit_in(instr_bit_in),
  .instr_discard_out(instr_discard_out), .skip_pending_out(skip_pending_out),
  .rf_rdata_in(rf_rdata_in), .rf_wr_out(rf_wr_out), .rf_waddr_out(rf_waddr_out),
  .rf_wdata_out(rf_wdata_out), .bus_wr_in(bus_wr_in), .acc_out(acc_out),
  .carry_out(carry_out), .nibble_half_flag_out(nibble_half_flag_out), .zero_out(zero_out));
